//--- common/homing_params.svh
// register offsets, field positions, reset values and timing counts of the homing block
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

`define HM_ADDR_CTRL 16'h6040
`define HM_ADDR_STAT 16'h6041
`define HM_ADDR_OFFS 16'h607C
`define HM_ADDR_METH 16'h6098
`define HM_ADDR_POS 16'h7000
`define HM_ADDR_IRQ_STAT 16'h7001
`define HM_ADDR_IRQ_MASK 16'h7002

`define HM_CW_START 4
`define HM_CW_HALT 8
`define HM_SW_INFO 7
`define HM_SW_INIT 9
`define HM_SW_TARGET 10
`define HM_SW_LIMIT 11
`define HM_SW_ATTAINED 12
`define HM_SW_ERROR 13
`define HM_SW_TORQUE 15

`define HM_M_LIM_NEG 8'h11
`define HM_M_LIM_POS 8'h12
`define HM_M_HOME_POS 8'h18
`define HM_M_HOME_NEG 8'h1C
`define HM_M_PRESET_A 8'h23
`define HM_M_PRESET_B 8'h25
`define HM_M_SPECIFIC 8'hFF
`define HM_METHOD_RST 8'h18

`define HM_IRQ_DONE 0
`define HM_IRQ_ALARM 1
`define HM_IRQ_ABORT 2

`define HM_CLK_HZ 20000000
`define HM_START_HZ 5000
`define HM_RUN_HZ 10000
`define HM_START_PERIOD 16'(`HM_CLK_HZ / `HM_START_HZ)
`define HM_RUN_PERIOD 16'(`HM_CLK_HZ / `HM_RUN_HZ)
`define HM_RAMP_DELTA 16'h0064

`endif

//--- common/homing_pkg.sv
// types shared by the homing block modules
package homing_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_STOPPING, ST_PRESET} hm_state_t;

    typedef enum logic [1:0] {RES_NONE, RES_RUN, RES_DONE, RES_ALARM} hm_result_t;

    typedef struct packed {
        logic [5:0] pin_s1;
        logic [5:0] pin_s2;
        logic [15:0] ctrl;
        logic [31:0] home_offset;
        logic [7:0] method;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] position;
        logic [31:0] rd_data;
        hm_state_t st;
        hm_result_t res;
        logic dir;
        logic ok_stop;
        logic go;
        logic decel;
        logic halt_now;
    } ctl_state_t;

    typedef struct packed {
        logic busy;
        logic stopping;
        logic step;
        logic [15:0] cnt;
        logic [15:0] period;
    } prof_state_t;

endpackage : homing_pkg

//--- common/homing_if.sv
// link between the homing sequencer and its step profile generator
`timescale 1ns/1ns
interface homing_if;
    logic go;
    logic decel_req;
    logic halt_now;
    logic step;
    logic moving;

    modport ctrl (output go, output decel_req, output halt_now, input step, input moving);
    modport gen (input go, input decel_req, input halt_now, output step, output moving);
endinterface : homing_if

//--- hw/homing_profile.sv
// step profile generator: ramps the step rate up, runs, and ramps down on request
`timescale 1ns/1ns
`include "homing_params.svh"
module homing_profile
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // sequencer side
    homing_if.gen pif
);

    homing_pkg::prof_state_t s;
    homing_pkg::prof_state_t n;

    // the trajectory is made here, never fed from outside
    always_comb
    begin
        n = s;
        n.step = 1'b0;
        if (!s.busy)
        begin
            if (pif.go)
            begin
                n.busy = 1'b1;
                n.stopping = 1'b0;
                n.period = `HM_START_PERIOD;
                n.cnt = `HM_START_PERIOD;
            end
        end
        else if (pif.halt_now)
        begin
            // alarm: no ramp, stop at once
            n.busy = 1'b0;
            n.stopping = 1'b0;
        end
        else
        begin
            if (pif.decel_req)
                n.stopping = 1'b1;
            if (s.cnt <= 16'h0001)
            begin
                n.step = 1'b1;
                n.cnt = s.period;
                if (n.stopping)
                begin
                    if (s.period >= `HM_START_PERIOD)
                        n.busy = 1'b0;
                    else
                        n.period = 16'(s.period + `HM_RAMP_DELTA);
                end
                else if (s.period > 16'(`HM_RUN_PERIOD + `HM_RAMP_DELTA))
                    n.period = 16'(s.period - `HM_RAMP_DELTA);
                else
                    n.period = `HM_RUN_PERIOD;
            end
            else
                n.cnt = 16'(s.cnt - 16'h0001);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end

    assign pif.step = s.step;
    assign pif.moving = s.busy;

endmodule : homing_profile

//--- hw/homing_mode_control.sv
// return-to-home sequencer with control word, status word and interrupt registers
`timescale 1ns/1ns
`include "homing_params.svh"
// Functional notes
// - The homing trajectory is generated inside the block with no setpoints from the master.
// - On successful completion the current position is preset to the home offset value.
// - Control bit 8 at 0 allows motion and at 1 stops it with a ramp.
// - A 0 to 1 change of control bit 4 starts homing unless something blocks it.
// - Dropping control bit 4 while homing runs ramps the motor to a stop.
// - Start is ignored while moving, halted, stop input on, not operation-enabled or not excited.
// - Status bit 15 shows that the load has reached the torque ceiling.
// - Status bit 11 is set while any limit sensor, travel block, software or mechanism limit is active.
// - Status bit 9 is set once initialization is complete.
// - Status bit 7 follows the information condition and clears on its own.
// - While homing runs, status bits 13, 12 and 10 read 000.
// - When homing was interrupted or never started, bits 13, 12 and 10 read 001.
// - After successful homing, bits 13, 12 and 10 read 011.
// - When an alarm cuts homing short, bits 13, 12 and 10 read 101.
// - The method code picks the procedure: 17/18 limit sensor, 24/28 home sensor, 35/37 preset, -1 specific.
module homing_mode_control
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [15:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rd_data,
    // sensor pins, bit 0 positive end
    input wire logic [1:0] travel_end_sensors,
    input wire logic [1:0] travel_block_inputs,
    input wire logic home_sensor,
    input wire logic stop_in,
    // drive internal conditions
    input wire logic op_enabled,
    input wire logic motor_excited,
    input wire logic drive_alarm,
    input wire logic info_active,
    input wire logic init_done,
    input wire logic torque_ceiling_flag,
    input wire logic soft_limit,
    input wire logic mech_limit,
    input wire logic [2:0] vendor_specific_bits,
    // motion and interrupt
    output logic step_out,
    output logic step_dir,
    output logic irq
);

    localparam int PIN_HOME = 0;
    localparam int PIN_BLK = 1;
    localparam int PIN_END = 3;
    localparam int PIN_STOP = 5;

    homing_pkg::ctl_state_t s;
    homing_pkg::ctl_state_t n;
    homing_if pif ();

    logic [2:0] ev;
    logic [2:0] irq_clr;
    logic [15:0] status_word;
    logic [5:0] pins;
    logic start_req;
    logic blocked;
    logic target_hit;
    logic any_limit;

    // procedure chosen by the method code
    function automatic logic method_ok(input logic [7:0] m);
        method_ok = (m == `HM_M_LIM_NEG) || (m == `HM_M_LIM_POS) || (m == `HM_M_HOME_POS)
            || (m == `HM_M_HOME_NEG) || (m == `HM_M_PRESET_A) || (m == `HM_M_PRESET_B)
            || (m == `HM_M_SPECIFIC);
    endfunction : method_ok

    function automatic logic method_preset(input logic [7:0] m);
        method_preset = (m == `HM_M_PRESET_A) || (m == `HM_M_PRESET_B);
    endfunction : method_preset

    // 1 means positive; the specific procedure seeks upward
    function automatic logic method_dir(input logic [7:0] m);
        method_dir = (m == `HM_M_LIM_POS) || (m == `HM_M_HOME_POS) || (m == `HM_M_SPECIFIC);
    endfunction : method_dir

    // only the four legal combinations can come out
    function automatic logic [2:0] result_code(input homing_pkg::hm_result_t r);
        case (r)
            homing_pkg::RES_RUN: result_code = 3'b000;
            homing_pkg::RES_DONE: result_code = 3'b011;
            homing_pkg::RES_ALARM: result_code = 3'b101;
            default: result_code = 3'b001;
        endcase
    endfunction : result_code

    assign pins = {stop_in, travel_end_sensors, travel_block_inputs, home_sensor};

    // start is judged on the written edge of bit 4
    assign start_req = wr_strobe && (addr == `HM_ADDR_CTRL)
        && wr_data[`HM_CW_START] && !s.ctrl[`HM_CW_START];

    // any of these swallows the start request
    assign blocked = (s.st != homing_pkg::ST_IDLE) || pif.moving || s.ctrl[`HM_CW_HALT]
        || s.pin_s2[PIN_STOP] || !op_enabled || !motor_excited;

    // limit methods look at the end sensor ahead, the rest at the home sensor
    always_comb
    begin
        if (s.method == `HM_M_LIM_NEG)
            target_hit = s.pin_s2[PIN_END + 1];
        else if (s.method == `HM_M_LIM_POS)
            target_hit = s.pin_s2[PIN_END];
        else
            target_hit = s.pin_s2[PIN_HOME];
    end

    assign any_limit = (|s.pin_s2[PIN_END +: 2]) || (|s.pin_s2[PIN_BLK +: 2])
        || soft_limit || mech_limit;

    always_comb
    begin
        status_word = 16'h0000;
        status_word[`HM_SW_TORQUE] = torque_ceiling_flag;
        status_word[`HM_SW_LIMIT] = any_limit;
        status_word[`HM_SW_INIT] = init_done;
        status_word[`HM_SW_INFO] = info_active;
        {status_word[`HM_SW_ERROR], status_word[`HM_SW_ATTAINED], status_word[`HM_SW_TARGET]}
            = result_code(s.res);
        status_word[14] = vendor_specific_bits[2];
        status_word[8] = vendor_specific_bits[1];
    end

    assign irq_clr = (wr_strobe && (addr == `HM_ADDR_IRQ_STAT)) ? wr_data[2:0] : 3'h0;

    always_comb
    begin
        n = s;
        ev = 3'h0;
        n.pin_s1 = pins;
        n.pin_s2 = s.pin_s1;
        n.go = 1'b0;
        n.halt_now = 1'b0;
        n.rd_data = 32'h0000_0000;
        if (wr_strobe)
        begin
            case (addr)
                `HM_ADDR_CTRL: n.ctrl = wr_data[15:0];
                `HM_ADDR_OFFS: n.home_offset = wr_data;
                `HM_ADDR_METH: n.method = wr_data[7:0];
                `HM_ADDR_IRQ_MASK: n.irq_mask = wr_data[2:0];
                default: ;
            endcase
        end
        if (pif.step)
            n.position = s.dir ? 32'(s.position + 32'h1) : 32'(s.position - 32'h1);
        case (s.st)
            homing_pkg::ST_IDLE:
            begin
                if (start_req && !blocked && method_ok(s.method))
                begin
                    n.res = homing_pkg::RES_RUN;
                    n.ok_stop = 1'b0;
                    if (method_preset(s.method))
                        n.st = homing_pkg::ST_PRESET;
                    else
                    begin
                        n.st = homing_pkg::ST_SEARCH;
                        n.dir = method_dir(s.method);
                        n.go = 1'b1;
                    end
                end
            end
            homing_pkg::ST_SEARCH:
            begin
                if (drive_alarm)
                begin
                    n.halt_now = 1'b1;
                    n.st = homing_pkg::ST_IDLE;
                    n.res = homing_pkg::RES_ALARM;
                    ev[`HM_IRQ_ALARM] = 1'b1;
                end
                else if (target_hit)
                begin
                    n.st = homing_pkg::ST_STOPPING;
                    n.ok_stop = 1'b1;
                    n.decel = 1'b1;
                end
                else if (!s.ctrl[`HM_CW_START] || s.ctrl[`HM_CW_HALT] || s.pin_s2[PIN_STOP])
                begin
                    // ramp down rather than drop the pulses
                    n.st = homing_pkg::ST_STOPPING;
                    n.ok_stop = 1'b0;
                    n.decel = 1'b1;
                end
            end
            homing_pkg::ST_STOPPING:
            begin
                if (drive_alarm)
                begin
                    n.halt_now = 1'b1;
                    n.decel = 1'b0;
                    n.st = homing_pkg::ST_IDLE;
                    n.res = homing_pkg::RES_ALARM;
                    ev[`HM_IRQ_ALARM] = 1'b1;
                end
                else if (!pif.moving)
                begin
                    n.decel = 1'b0;
                    if (s.ok_stop)
                        n.st = homing_pkg::ST_PRESET;
                    else
                    begin
                        n.st = homing_pkg::ST_IDLE;
                        n.res = homing_pkg::RES_NONE;
                        ev[`HM_IRQ_ABORT] = 1'b1;
                    end
                end
            end
            homing_pkg::ST_PRESET:
            begin
                // overrides any last step count in the same cycle
                n.position = s.home_offset;
                n.res = homing_pkg::RES_DONE;
                n.st = homing_pkg::ST_IDLE;
                ev[`HM_IRQ_DONE] = 1'b1;
            end
            default:
                n.st = homing_pkg::ST_IDLE;
        endcase
        // a new event beats a clear written in the same cycle
        n.irq_stat = (s.irq_stat & ~irq_clr) | ev;
        if (rd_strobe)
        begin
            case (addr)
                `HM_ADDR_CTRL: n.rd_data = {16'h0000, s.ctrl};
                `HM_ADDR_STAT: n.rd_data = {16'h0000, status_word};
                `HM_ADDR_OFFS: n.rd_data = s.home_offset;
                `HM_ADDR_METH: n.rd_data = {24'h00_0000, s.method};
                `HM_ADDR_POS: n.rd_data = s.position;
                `HM_ADDR_IRQ_STAT: n.rd_data = {29'h0000_0000, s.irq_stat};
                `HM_ADDR_IRQ_MASK: n.rd_data = {29'h0000_0000, s.irq_mask};
                default: n.rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.method <= `HM_METHOD_RST;
        end
        else
            s <= n;
    end

    assign pif.go = s.go;
    assign pif.decel_req = s.decel;
    assign pif.halt_now = s.halt_now;

    homing_profile u_profile
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pif(pif)
    );

    assign rd_data = s.rd_data;
    assign step_out = pif.step;
    assign step_dir = s.dir;
    assign irq = |(s.irq_stat & s.irq_mask);

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    logic [2:0] code;
    assign code = {status_word[`HM_SW_ERROR], status_word[`HM_SW_ATTAINED], status_word[`HM_SW_TARGET]};

    start_ignore_a: assert property (
        (start_req && s.st == homing_pkg::ST_IDLE && blocked) |=> s.st == homing_pkg::ST_IDLE)
        else $error("blocked start was taken");

    start_go_a: assert property (
        (start_req && !blocked && method_ok(s.method) && !method_preset(s.method))
        |=> (s.st == homing_pkg::ST_SEARCH && s.go) ##1 pif.moving)
        else $error("start did not launch motion");

    preset_pos_a: assert property (
        s.st == homing_pkg::ST_PRESET |=> s.position == $past(s.home_offset))
        else $error("position not preset to home offset");

    run_code_a: assert property (
        (s.st == homing_pkg::ST_SEARCH || s.st == homing_pkg::ST_STOPPING) |-> code == 3'b000)
        else $error("running code wrong");

    done_code_a: assert property (
        s.st == homing_pkg::ST_PRESET |=> code == 3'b011 && s.st == homing_pkg::ST_IDLE)
        else $error("completion code wrong");

    alarm_code_a: assert property (
        (drive_alarm && s.st == homing_pkg::ST_SEARCH) |=> code == 3'b101 ##1 !pif.moving)
        else $error("alarm interruption not reported");

    legal_code_a: assert property (
        code == 3'b000 || code == 3'b001 || code == 3'b011 || code == 3'b101)
        else $error("illegal status combination");

    limit_bit_a: assert property (
        status_word[`HM_SW_LIMIT] == ((|$past(travel_end_sensors, 2)) || (|$past(travel_block_inputs, 2))
        || soft_limit || mech_limit))
        else $error("limit bit does not follow limit sources");

    abort_decel_a: assert property (
        (s.st == homing_pkg::ST_SEARCH && !drive_alarm && !target_hit && !s.ctrl[`HM_CW_START])
        |=> s.st == homing_pkg::ST_STOPPING && s.decel)
        else $error("start drop did not decelerate");

    halt_stop_a: assert property (
        (s.st == homing_pkg::ST_SEARCH && !drive_alarm && s.ctrl[`HM_CW_HALT])
        |=> s.st == homing_pkg::ST_STOPPING)
        else $error("halt did not stop homing");

    status_read_a: assert property (
        (rd_strobe && addr == `HM_ADDR_STAT) |=> rd_data == {16'h0000, $past(status_word)})
        else $error("status read data wrong");

    abort_code_a: assert property (
        (s.st == homing_pkg::ST_STOPPING && !s.ok_stop && !drive_alarm && !pif.moving)
        |=> code == 3'b001 && s.irq_stat[`HM_IRQ_ABORT])
        else $error("interrupted homing not reported");

    homing_done_c: cover property (s.st == homing_pkg::ST_STOPPING && s.ok_stop ##[1:40] code == 3'b011);
    alarm_abort_c: cover property (s.st == homing_pkg::ST_SEARCH ##1 code == 3'b101);
    halt_abort_c: cover property (s.st == homing_pkg::ST_STOPPING && !s.ok_stop ##[1:40] code == 3'b001);
    preset_done_c: cover property ((start_req && !blocked && method_preset(s.method)) ##2 code == 3'b011);

endmodule : homing_mode_control

//--- verification/axis_rig.sv
// axis model: counts steps and closes the home and end sensors after a set travel
`timescale 1ns/1ns
module axis_rig
#(
    parameter int HOME_STEPS = 1
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // motion from the drive
    input wire logic step_out,
    input wire logic step_dir,
    input wire logic rearm,
    // sensors back to the drive
    output logic home_sensor,
    output logic [1:0] travel_end_sensors
);
    int travel;
    logic moved_pos;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            travel <= 0;
            moved_pos <= 1'b1;
        end
        else if (rearm)
            travel <= 0;
        else if (step_out)
        begin
            travel <= travel + 1;
            moved_pos <= step_dir;
        end
    end

    // sensors stay closed while the carriage sits past the mark, so the bench must rearm between runs
    assign home_sensor = (travel >= HOME_STEPS);
    assign travel_end_sensors = {home_sensor & ~moved_pos, home_sensor & moved_pos};
endmodule : axis_rig

//--- verification/testbench.sv
// self-checking bench for the homing sequencer
`timescale 1ns/1ns
`include "homing_params.svh"
module testbench;
    localparam logic [15:0] a_ctrl = `HM_ADDR_CTRL;
    localparam logic [15:0] a_stat = `HM_ADDR_STAT;
    localparam logic [15:0] a_pos = `HM_ADDR_POS;
    localparam logic [15:0] a_ist = `HM_ADDR_IRQ_STAT;
    localparam logic [31:0] offs = 32'hFFFF_FF38;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wr_data = 32'h0000_0000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [31:0] rd_data;
    logic [1:0] travel_end_sensors;
    logic [1:0] travel_block_inputs = 2'h0;
    logic home_sensor;
    logic stop_in = 1'b0;
    logic op_enabled = 1'b1;
    logic motor_excited = 1'b1;
    logic drive_alarm = 1'b0;
    logic info_active = 1'b0;
    logic init_done = 1'b0;
    logic torque_ceiling_flag = 1'b0;
    logic soft_limit = 1'b0;
    logic mech_limit = 1'b0;
    logic [2:0] vendor_specific_bits = 3'h5;
    logic step_out;
    logic step_dir;
    logic irq;
    logic rearm = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rv;
    logic [31:0] pv;
    logic [7:0] meth [5] = '{8'h11, 8'h12, 8'h18, 8'h1C, 8'hFF};
    logic dirs [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    always #25 sys_clk = ~sys_clk;

    homing_mode_control i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .travel_end_sensors(travel_end_sensors),
        .travel_block_inputs(travel_block_inputs), .home_sensor(home_sensor), .stop_in(stop_in),
        .op_enabled(op_enabled), .motor_excited(motor_excited), .drive_alarm(drive_alarm),
        .info_active(info_active), .init_done(init_done), .torque_ceiling_flag(torque_ceiling_flag),
        .soft_limit(soft_limit), .mech_limit(mech_limit), .vendor_specific_bits(vendor_specific_bits),
        .step_out(step_out), .step_dir(step_dir), .irq(irq));

    axis_rig i_rig (.sys_clk(sys_clk), .rst_b(rst_b), .step_out(step_out), .step_dir(step_dir),
        .rearm(rearm), .home_sensor(home_sensor), .travel_end_sensors(travel_end_sensors));

    task automatic final_report();
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_rd

    task automatic check_code(input logic [2:0] exp);
        logic [2:0] c;
        reg_rd(a_stat, rv);
        c = {rv[`HM_SW_ERROR], rv[`HM_SW_ATTAINED], rv[`HM_SW_TARGET]};
        check(32'(c), 32'(exp));
        check(32'(c inside {3'b010, 3'b100, 3'b110, 3'b111}), 32'h0);
    endtask : check_code

    task automatic wait_irq(input int idx);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (irq !== 1'b1)
        begin
            fail_count++;
            $display("[ERR] %0t interrupt never came", $time);
            final_report();
        end
        else
        begin
            reg_rd(a_ist, rv);
            check(rv, 32'h1 << idx);
            reg_wr(a_ist, 32'h7);
        end
    endtask : wait_irq

    task automatic rearm_axis();
        @(posedge sys_clk);
        rearm <= 1'b1;
        @(posedge sys_clk);
        rearm <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : rearm_axis

    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        reg_rd(a_ctrl, rv);
        check(rv, 32'h0);
        reg_rd(`HM_ADDR_METH, rv);
        check(rv, 32'h18);
        check_code(3'b001);
        info_active <= 1'b1;
        init_done <= 1'b1;
        torque_ceiling_flag <= 1'b1;
        reg_rd(a_stat, rv);
        check(32'(rv[`HM_SW_TORQUE]), 32'h1);
        check(32'(rv[`HM_SW_INIT]), 32'h1);
        check(32'(rv[`HM_SW_INFO]), 32'h1);
        check(32'({rv[14], rv[8]}), 32'h2);
        for (int k = 0; k < 4; k++)
        begin
            {mech_limit, soft_limit, travel_block_inputs} <= 4'(1 << k);
            repeat (3) @(posedge sys_clk);
            reg_rd(a_stat, rv);
            check(32'(rv[`HM_SW_LIMIT]), 32'h1);
        end
        {mech_limit, soft_limit, travel_block_inputs, info_active, torque_ceiling_flag} <= 6'h00;
        repeat (3) @(posedge sys_clk);
        reg_rd(a_stat, rv);
        check(32'({rv[`HM_SW_TORQUE], rv[`HM_SW_LIMIT], rv[`HM_SW_INFO]}), 32'h0);
        reg_wr(`HM_ADDR_OFFS, offs);
        for (int i = 0; i < 2; i++)
        begin
            reg_wr(`HM_ADDR_METH, i ? 32'h25 : 32'h23);
            reg_wr(a_ctrl, 32'h10);
            check_code(3'b011);
            reg_rd(a_pos, rv);
            check(rv, offs);
            reg_wr(a_ctrl, 32'h0);
        end
        check(32'(irq), 32'h0);
        reg_wr(`HM_ADDR_IRQ_MASK, 32'h7);
        #1;
        check(32'(irq), 32'h1);
        reg_wr(a_ist, 32'h1);
        #1;
        check(32'(irq), 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            rearm_axis();
            reg_wr(`HM_ADDR_METH, {24'h0, meth[i]});
            reg_wr(a_ctrl, 32'h10);
            // direction register updates on the edge that took the write
            #1;
            check(32'(step_dir), 32'(dirs[i]));
            check_code(3'b000);
            wait_irq(0);
            check(32'(home_sensor), 32'h1);
            check_code(3'b011);
            reg_rd(a_pos, rv);
            check(rv, offs);
            reg_wr(a_ctrl, 32'h0);
        end
        reg_wr(`HM_ADDR_METH, 32'h18);
        for (int k = 0; k < 3; k++)
        begin
            rearm_axis();
            reg_wr(a_ctrl, 32'h10);
            if (k == 0)
                reg_wr(a_ctrl, 32'h0);
            else if (k == 1)
                reg_wr(a_ctrl, 32'h110);
            else
                stop_in <= 1'b1;
            wait_irq(2);
            check_code(3'b001);
            stop_in <= 1'b0;
            reg_wr(a_ctrl, 32'h0);
        end
        rearm_axis();
        reg_wr(a_ctrl, 32'h10);
        drive_alarm <= 1'b1;
        wait_irq(1);
        check_code(3'b101);
        drive_alarm <= 1'b0;
        reg_wr(a_ctrl, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 0)
                reg_wr(a_ctrl, 32'h100);
            stop_in <= (k == 1);
            op_enabled <= (k != 2);
            motor_excited <= (k != 3);
            repeat (3) @(posedge sys_clk);
            reg_wr(a_ctrl, k == 0 ? 32'h110 : 32'h10);
            check_code(3'b101);
            {stop_in, op_enabled, motor_excited} <= 3'b011;
            reg_wr(a_ctrl, 32'h0);
        end
        reg_rd(a_pos, pv);
        reg_wr(a_stat, 32'hFFFF);
        reg_wr(a_pos, 32'h0);
        check_code(3'b101);
        reg_rd(a_pos, rv);
        check(rv, pv);
        reg_rd(16'h1234, rv);
        check(rv, 32'h0);
        final_report();
    end
endmodule : testbench
